// [rtl/iup_presenter.sv]
`timescale 1ns/1ps
module iup_presenter
  import iup_pkg::*;
(
  input wire logic i_mclk,
  input wire logic i_rst_b,
  iup_if.dev bus,
  input wire logic [NUM_SRC-1:0] i_src_irq,
  input wire logic [NUM_SRC-1:0] i_cmpl_src,
  input wire logic i_wr_pending,
  output logic o_flush_req,
  output logic [NUM_SRC-1:0] o_masked
);
  // ********************************************************
  // Source synchronisers.
  // ********************************************************
  logic [NUM_SRC-1:0] s1_r;
  logic [NUM_SRC-1:0] s2_r;
  logic [NUM_SRC-1:0] s3_r;
  logic [NUM_SRC-1:0] lvl_r;
  logic [NUM_SRC-1:0] lvl_nxt;

  always_ff @(posedge i_mclk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      s1_r <= '0;
      s2_r <= '0;
      s3_r <= '0;
      lvl_r <= '0;
    end else begin
      s1_r <= i_src_irq;
      s2_r <= s1_r;
      s3_r <= s2_r;
      lvl_r <= lvl_nxt;
    end
  end

  genvar g;
  generate
    for (g = 0; g < NUM_SRC; g++) begin : g_lvl
      assign lvl_nxt[g] = (s2_r[g] == s3_r[g]) ? s3_r[g] : lvl_r[g];
    end
  endgenerate

  // ********************************************************
  // Presentation state.
  // ********************************************************
  typedef enum logic [1:0] {ST_IDLE, ST_PRESENT, ST_WAIT} iup_state_e;

  iup_state_e state_r;
  iup_state_e state_nxt;
  logic [NUM_SRC-1:0] mask_r;
  logic [NUM_SRC-1:0] mask_nxt;
  logic [3:0] retry_r;
  logic [3:0] retry_nxt;
  logic [SRC_W-1:0] cur_r;
  logic [SRC_W-1:0] cur_nxt;
  logic [7:0] server_r;
  logic [7:0] server_nxt;
  logic [7:0] prio_r;
  logic [7:0] prio_nxt;
  logic [UNIT_W-1:0] unit_r;
  logic [UNIT_W-1:0] unit_nxt;
  logic [31:0] vec_r [NUM_SRC];
  logic [31:0] vec_nxt [NUM_SRC];
  logic ack_r;
  logic ack_nxt;
  logic [31:0] rdata_r;
  logic [31:0] rdata_nxt;
  logic [NUM_SRC-1:0] eligible;
  logic found;
  logic [SRC_W-1:0] sel;
  logic acc_new;
  logic [SRC_W-1:0] acc_idx;
  logic acc_eoi;

  // Completion sources are held back while their data is still in flight.
  assign eligible = lvl_r & ~mask_r & ~(i_cmpl_src & {NUM_SRC{i_wr_pending}}); // [RL16]
  // Asking the write path to drain keeps software out of the flush entirely.
  assign o_flush_req = |(lvl_r & ~mask_r & i_cmpl_src) & i_wr_pending; // [RL18] [RL17]
  assign acc_new = bus.acc_req & ~ack_r;
  assign acc_idx = bus.acc_addr[SRC_W-1:0];
  assign acc_eoi = bus.acc_addr[EOI_SEL_BIT];

  // ********************************************************
  // Source selection.
  // ********************************************************
  always_comb begin
    found = 1'b0;
    sel = '0;
    for (int i = NUM_SRC - 1; i >= 0; i--) begin
      if (eligible[i]) begin
        found = 1'b1;
        sel = i[SRC_W-1:0]; // [RL21] [RL5]
      end
    end
  end

  always_comb begin
    state_nxt = state_r;
    mask_nxt = mask_r;
    retry_nxt = retry_r;
    cur_nxt = cur_r;
    server_nxt = server_r;
    prio_nxt = prio_r;
    unit_nxt = unit_r;
    // Clears come first so that a mask set in the same cycle wins.
    if (acc_new && acc_eoi) begin
      mask_nxt[acc_idx] = 1'b0; // [RL11] [RL12] [RL13] [RL14]
    end
    if (bus.late_reject) begin
      mask_nxt[bus.late_src] = 1'b0; // [RL8]
    end
    case (state_r)
      ST_IDLE: begin
        if (found) begin
          mask_nxt[sel] = 1'b1; // [RL10]
          cur_nxt = sel;
          server_nxt = vec_r[sel][SERVER_MSB:SERVER_LSB]; // [RL3]
          prio_nxt = vec_r[sel][PRIO_MSB:PRIO_LSB]; // [RL4]
          unit_nxt = BASE_UNIT_ID; // [RL2] [RL6]
          state_nxt = ST_PRESENT;
        end
      end
      ST_PRESENT: begin
        if (bus.pres_accept) begin
          state_nxt = ST_IDLE;
        end else if (bus.pres_reject) begin
          mask_nxt[cur_r] = 1'b0; // [RL7]
          retry_nxt = RETRY_LOAD;
          state_nxt = ST_WAIT;
        end
      end
      ST_WAIT: begin
        // A pause before retrying keeps a busy router from being flooded.
        if (retry_r <= 4'h1) begin
          state_nxt = ST_IDLE;
        end else begin
          retry_nxt = retry_r - 4'h1;
        end
      end
      default: begin
        state_nxt = ST_IDLE;
      end
    endcase
  end

  // ********************************************************
  // Vector entries and access port.
  // ********************************************************
  always_comb begin
    for (int i = 0; i < NUM_SRC; i++) begin
      vec_nxt[i] = vec_r[i];
    end
    ack_nxt = acc_new;
    rdata_nxt = rdata_r;
    if (acc_new) begin
      if (acc_eoi) begin
        rdata_nxt = '0;
      end else if (bus.acc_we) begin
        vec_nxt[acc_idx] = bus.acc_wdata & VEC_STORE_MASK; // [RL1] [RL3]
      end else begin
        rdata_nxt = vec_r[acc_idx];
      end
    end
  end

  always_ff @(posedge i_mclk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      state_r <= ST_IDLE;
      mask_r <= '0;
      retry_r <= '0;
      cur_r <= '0;
      server_r <= '0;
      prio_r <= '0;
      unit_r <= '0;
      ack_r <= 1'b0;
      rdata_r <= '0;
      for (int i = 0; i < NUM_SRC; i++) begin
        vec_r[i] <= VEC_RESET;
      end
    end else begin
      state_r <= state_nxt;
      mask_r <= mask_nxt;
      retry_r <= retry_nxt;
      cur_r <= cur_nxt;
      server_r <= server_nxt;
      prio_r <= prio_nxt;
      unit_r <= unit_nxt;
      ack_r <= ack_nxt;
      rdata_r <= rdata_nxt;
      for (int i = 0; i < NUM_SRC; i++) begin
        vec_r[i] <= vec_nxt[i];
      end
    end
  end

  // ********************************************************
  // Interface outputs.
  // ********************************************************
  assign bus.pres_valid = (state_r == ST_PRESENT); // [RL6]
  assign bus.pres_server = server_r;
  assign bus.pres_prio = prio_r;
  assign bus.pres_src = cur_r;
  assign bus.pres_unit = unit_r;
  assign bus.acc_ack = ack_r;
  assign bus.acc_rdata = rdata_r;
  assign o_masked = mask_r;
endmodule : iup_presenter

// [rtl/iup_pkg.sv]
// How it works
// [RL1] One vector entry per interrupt source.
// [RL2] Sixteen entries per unit identifier, consecutive identifiers.
// [RL3] Bits 16-23 server number, 0-15 reserved.
// [RL4] Bits 24-31 carry the presentation priority.
// [RL5] Unit logic picks pending source, selects entry.
// [RL6] Presentation sends entry, source and unit identifier.
// [RL7] Rejected, still set: present again later.
// [RL8] Late rejection after acceptance also re-presents.
// [RL9] Firmware writes every entry before enabling.
// [RL10] Presented source masked so it shows once.
// [RL11] Load or store to end location commands.
// [RL12] End command unmasks exactly like a rejection.
// [RL13] Address carries the source number to unmask.
// [RL14] Presenting units implement the end command.
// [RL15] Software ends service after clearing the source.
// [RL16] Completion interrupts wait until data is visible.
// [RL17] Written data becomes visible in write order.
// [RL18] Flushing for visibility needs no software action.
// [RL19] Software marks shared pages as coherent.
// [RL20] Entries live in translated or untranslated space.
// [RL21] Lowest-numbered pending source is presented first.
package iup_pkg;
  // ********************************************************
  // Sizes and field layout.
  // ********************************************************
  localparam int NUM_SRC = 16;
  localparam int SRC_W = 4;
  localparam int UNIT_W = 8;
  localparam int ADDR_W = 5;
  localparam int EOI_SEL_BIT = 4;
  localparam int SERVER_LSB = 16;
  localparam int SERVER_MSB = 23;
  localparam int PRIO_LSB = 24;
  localparam int PRIO_MSB = 31;
  localparam logic [31:0] VEC_RESET = 32'h0000_0000;
  localparam logic [31:0] VEC_STORE_MASK = 32'hffff_0000;
  // Arbitrary first unit identifier of this unit.
  localparam logic [UNIT_W-1:0] BASE_UNIT_ID = 8'h20;
  // Set for the translated address space.
  localparam logic ADDR_SPACE_T = 1'b1; // [RL20]
  // ********************************************************
  // Timing.
  // ********************************************************
  localparam int CLK_NS = 40;
  localparam int RETRY_NS = 400;
  localparam int RETRY_CYC = (RETRY_NS + CLK_NS - 1) / CLK_NS;
  localparam logic [3:0] RETRY_LOAD = RETRY_CYC[3:0];
  // ********************************************************
  // Controller registers on APB.
  // ********************************************************
  localparam logic [11:0] OFF_PRIO = 12'h000;
  localparam logic [11:0] OFF_TAKEN = 12'h004;
  localparam logic [11:0] OFF_CMD = 12'h008;
  localparam logic [11:0] OFF_DATA = 12'h00c;
  localparam logic [7:0] PRIO_RESET = 8'hff;
  localparam int TAKEN_VALID_BIT = 31;
  localparam int CMD_WE_BIT = 31;
  localparam int CMD_BUSY_BIT = 0;
endpackage : iup_pkg

// [rtl/iup_if.sv]
`timescale 1ns/1ps
interface iup_if;
  import iup_pkg::*;
  logic pres_valid;
  logic [7:0] pres_server;
  logic [7:0] pres_prio;
  logic [SRC_W-1:0] pres_src;
  logic [UNIT_W-1:0] pres_unit;
  logic pres_accept;
  logic pres_reject;
  logic late_reject;
  logic [SRC_W-1:0] late_src;
  logic acc_req;
  logic acc_we;
  logic [ADDR_W-1:0] acc_addr;
  logic [31:0] acc_wdata;
  logic acc_ack;
  logic [31:0] acc_rdata;
  modport dev (
    output pres_valid, pres_server, pres_prio, pres_src, pres_unit, acc_ack, acc_rdata,
    input pres_accept, pres_reject, late_reject, late_src, acc_req, acc_we, acc_addr, acc_wdata
  );
  modport rtr (
    input pres_valid, pres_server, pres_prio, pres_src, pres_unit, acc_ack, acc_rdata,
    output pres_accept, pres_reject, late_reject, late_src, acc_req, acc_we, acc_addr, acc_wdata
  );
endinterface : iup_if

// [rtl/iup_router.sv]
`timescale 1ns/1ps
module iup_router
  import iup_pkg::*;
(
  input wire logic i_mclk,
  input wire logic i_rst_b,
  iup_if.rtr bus,
  input wire logic i_psel,
  input wire logic i_penable,
  input wire logic i_pwrite,
  input wire logic [11:0] i_paddr,
  input wire logic [31:0] i_pwdata,
  output logic [31:0] o_prdata,
  output logic o_pready,
  output logic o_pslverr
);
  // ********************************************************
  // Routing and controller state.
  // ********************************************************
  logic [7:0] current_processor_priority_r, current_processor_priority_nxt;
  logic held_r, held_nxt;
  logic [SRC_W-1:0] hsrc_r, hsrc_nxt;
  logic [7:0] hserver_r, hserver_nxt;
  logic [7:0] hprio_r, hprio_nxt;
  logic [UNIT_W-1:0] hunit_r, hunit_nxt;
  logic acc_r, acc_nxt;
  logic rej_r, rej_nxt;
  logic late_r, late_nxt;
  logic [SRC_W-1:0] lsrc_r, lsrc_nxt;
  logic req_r, req_nxt;
  logic we_r, we_nxt;
  logic [ADDR_W-1:0] addr_r, addr_nxt;
  logic [31:0] wdata_r, wdata_nxt;
  logic [31:0] rd_r, rd_nxt;
  logic [31:0] prdata_r, prdata_nxt;
  logic wr;

  assign wr = i_psel & i_penable & i_pwrite;

  always_comb begin
    current_processor_priority_nxt = current_processor_priority_r;
    held_nxt = held_r;
    hsrc_nxt = hsrc_r;
    hserver_nxt = hserver_r;
    hprio_nxt = hprio_r;
    hunit_nxt = hunit_r;
    acc_nxt = 1'b0;
    rej_nxt = 1'b0;
    late_nxt = 1'b0;
    lsrc_nxt = lsrc_r;
    req_nxt = req_r;
    we_nxt = we_r;
    addr_nxt = addr_r;
    wdata_nxt = wdata_r;
    rd_nxt = rd_r;
    prdata_nxt = prdata_r;
    // Software clears come first so that a same-cycle acceptance is never lost.
    if (wr && i_paddr == OFF_PRIO) begin
      current_processor_priority_nxt = i_pwdata[7:0];
      if (held_r && (hprio_r >= i_pwdata[7:0])) begin
        late_nxt = 1'b1; // [RL8]
        lsrc_nxt = hsrc_r;
        held_nxt = 1'b0;
      end
    end
    if (wr && i_paddr == OFF_TAKEN) begin
      held_nxt = 1'b0;
    end
    // One answer per presentation; the response flops block a second one.
    if (bus.pres_valid && !acc_r && !rej_r) begin
      if (!held_r && (bus.pres_prio < current_processor_priority_r)) begin
        acc_nxt = 1'b1;
        held_nxt = 1'b1;
        hsrc_nxt = bus.pres_src;
        hserver_nxt = bus.pres_server;
        hprio_nxt = bus.pres_prio;
        hunit_nxt = bus.pres_unit;
      end else begin
        rej_nxt = 1'b1; // [RL7]
      end
    end
    // A new access while one is in flight is dropped, not queued.
    if (wr && i_paddr == OFF_DATA && !req_r) begin
      wdata_nxt = i_pwdata;
    end
    if (wr && i_paddr == OFF_CMD && !req_r) begin
      req_nxt = 1'b1; // [RL9] [RL15] [RL11]
      we_nxt = i_pwdata[CMD_WE_BIT];
      addr_nxt = i_pwdata[ADDR_W-1:0];
    end
    if (req_r && bus.acc_ack) begin
      req_nxt = 1'b0;
      if (!we_r) begin
        rd_nxt = bus.acc_rdata;
      end
    end
    if (i_psel && !i_penable) begin
      case (i_paddr)
        OFF_PRIO: prdata_nxt = {24'h00_0000, current_processor_priority_r};
        OFF_TAKEN: prdata_nxt = {held_r, 3'h0, hsrc_r, hserver_r, hprio_r, hunit_r};
        OFF_CMD: prdata_nxt = {31'h0000_0000, req_r};
        OFF_DATA: prdata_nxt = rd_r;
        default: prdata_nxt = '0;
      endcase
    end
  end

  always_ff @(posedge i_mclk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      current_processor_priority_r <= PRIO_RESET;
      held_r <= 1'b0;
      hsrc_r <= '0;
      hserver_r <= '0;
      hprio_r <= '0;
      hunit_r <= '0;
      acc_r <= 1'b0;
      rej_r <= 1'b0;
      late_r <= 1'b0;
      lsrc_r <= '0;
      req_r <= 1'b0;
      we_r <= 1'b0;
      addr_r <= '0;
      wdata_r <= '0;
      rd_r <= '0;
      prdata_r <= '0;
    end else begin
      current_processor_priority_r <= current_processor_priority_nxt;
      held_r <= held_nxt;
      hsrc_r <= hsrc_nxt;
      hserver_r <= hserver_nxt;
      hprio_r <= hprio_nxt;
      hunit_r <= hunit_nxt;
      acc_r <= acc_nxt;
      rej_r <= rej_nxt;
      late_r <= late_nxt;
      lsrc_r <= lsrc_nxt;
      req_r <= req_nxt;
      we_r <= we_nxt;
      addr_r <= addr_nxt;
      wdata_r <= wdata_nxt;
      rd_r <= rd_nxt;
      prdata_r <= prdata_nxt;
    end
  end

  assign bus.pres_accept = acc_r;
  assign bus.pres_reject = rej_r;
  assign bus.late_reject = late_r;
  assign bus.late_src = lsrc_r;
  assign bus.acc_req = req_r;
  assign bus.acc_we = we_r;
  assign bus.acc_addr = addr_r;
  assign bus.acc_wdata = wdata_r;
  assign o_prdata = prdata_r;
  assign o_pready = 1'b1;
  assign o_pslverr = 1'b0;
endmodule : iup_router

// [verification/iup_monitor.sv]
`timescale 1ns/1ps
module iup_monitor
  import iup_pkg::*;
(
  input wire logic i_mclk,
  input wire logic i_rst_b,
  input wire logic pres_valid,
  input wire logic [7:0] pres_server,
  input wire logic [7:0] pres_prio,
  input wire logic [SRC_W-1:0] pres_src,
  input wire logic [UNIT_W-1:0] pres_unit,
  input wire logic pres_accept,
  input wire logic pres_reject,
  input wire logic late_reject,
  input wire logic [SRC_W-1:0] late_src,
  input wire logic acc_req,
  input wire logic acc_we,
  input wire logic [ADDR_W-1:0] acc_addr,
  input wire logic [31:0] acc_wdata,
  input wire logic acc_ack,
  input wire logic [31:0] acc_rdata
);
  // ****************
  // Accepted sources that nothing has released yet.
  // ****************
  logic [NUM_SRC-1:0] held_r;
  logic [NUM_SRC-1:0] held_nxt;
  always_comb begin
    held_nxt = held_r;
    if (late_reject) held_nxt[late_src] = 1'b0;
    if (acc_ack && acc_addr[EOI_SEL_BIT]) held_nxt[acc_addr[SRC_W-1:0]] = 1'b0;
    if (pres_accept) held_nxt[pres_src] = 1'b1;
  end
  always_ff @(posedge i_mclk or negedge i_rst_b) begin
    if (!i_rst_b) held_r <= '0;
    else held_r <= held_nxt;
  end
  default clocking @(posedge i_mclk); endclocking
  default disable iff (!i_rst_b);
  property p_unit;
    pres_valid |-> pres_unit == BASE_UNIT_ID;
  endproperty
  a_unit: assert property (p_unit) else $error("wrong unit identifier");
  property p_stable;
    pres_valid && !pres_accept && !pres_reject |=> pres_valid && $stable({pres_server, pres_prio, pres_src});
  endproperty
  a_stable: assert property (p_stable) else $error("presentation changed");
  property p_answer;
    $rose(pres_valid) |=> pres_accept || pres_reject;
  endproperty
  a_answer: assert property (p_answer) else $error("no routing answer");
  property p_retry;
    pres_reject |=> !pres_valid [*8];
  endproperty
  a_retry: assert property (p_retry) else $error("retry too soon");
  property p_held;
    pres_valid |-> !held_r[pres_src];
  endproperty
  a_held: assert property (p_held) else $error("masked source presented");
  property p_ack;
    acc_req && !acc_ack |=> acc_ack;
  endproperty
  a_ack: assert property (p_ack) else $error("access not answered");
  property p_acc_hold;
    acc_req && !acc_ack |=> $stable({acc_we, acc_addr, acc_wdata});
  endproperty
  a_acc_hold: assert property (p_acc_hold) else $error("access request changed");
  property p_pulse;
    acc_ack |=> !acc_ack && !acc_req;
  endproperty
  a_pulse: assert property (p_pulse) else $error("ack not a pulse");
  property p_eos;
    acc_ack && acc_addr[EOI_SEL_BIT] && !acc_we |-> acc_rdata == 32'h0;
  endproperty
  a_eos: assert property (p_eos) else $error("end load data nonzero");
  property p_resv;
    acc_ack && !acc_addr[EOI_SEL_BIT] && !acc_we |-> acc_rdata[15:0] == 16'h0;
  endproperty
  a_resv: assert property (p_resv) else $error("reserved bits set");
  c_accept: cover property (pres_accept);
  c_reject: cover property (pres_reject);
  c_late: cover property (late_reject);
  c_eos: cover property (acc_ack && acc_addr[EOI_SEL_BIT]);
endmodule : iup_monitor

// [verification/io_unit_interrupt_presenter_tb.sv]
`timescale 1ns/1ps
module io_unit_interrupt_presenter_tb;
  import iup_pkg::*;
  logic mclk;
  logic rst_b;
  logic [NUM_SRC-1:0] src_irq;
  logic [NUM_SRC-1:0] cmpl_src;
  logic wr_pend;
  logic flush_req;
  logic [NUM_SRC-1:0] masked;
  logic psel;
  logic penable;
  logic pwrite;
  logic [11:0] paddr;
  logic [31:0] pwdata;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic [31:0] q;
  int n_fail;
  int num_checks;
  iup_if bus_if ();
  iup_presenter i_iup_presenter (.i_mclk(mclk), .i_rst_b(rst_b), .bus(bus_if), .i_src_irq(src_irq),
    .i_cmpl_src(cmpl_src), .i_wr_pending(wr_pend), .o_flush_req(flush_req), .o_masked(masked));
  iup_router i_iup_router (.i_mclk(mclk), .i_rst_b(rst_b), .bus(bus_if), .i_psel(psel), .i_penable(penable),
    .i_pwrite(pwrite), .i_paddr(paddr), .i_pwdata(pwdata), .o_prdata(prdata), .o_pready(pready),
    .o_pslverr(pslverr));
  iup_monitor i_iup_monitor (.i_mclk(mclk), .i_rst_b(rst_b), .pres_valid(bus_if.pres_valid),
    .pres_server(bus_if.pres_server), .pres_prio(bus_if.pres_prio), .pres_src(bus_if.pres_src),
    .pres_unit(bus_if.pres_unit), .pres_accept(bus_if.pres_accept), .pres_reject(bus_if.pres_reject),
    .late_reject(bus_if.late_reject), .late_src(bus_if.late_src), .acc_req(bus_if.acc_req),
    .acc_we(bus_if.acc_we), .acc_addr(bus_if.acc_addr), .acc_wdata(bus_if.acc_wdata),
    .acc_ack(bus_if.acc_ack), .acc_rdata(bus_if.acc_rdata));
  initial begin
    mclk = 1'b0;
    forever #20 mclk = ~mclk;
  end
  // ****************
  // Bench tasks.
  // ****************
  task automatic finish_test;
    $display("checks %0d mismatches %0d", num_checks, n_fail);
    if (n_fail == 0 && num_checks > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask : finish_test
  task automatic tmo;
    n_fail++;
    finish_test();
  endtask : tmo
  task automatic chk(input string nm, input logic [31:0] s, input logic [31:0] e);
    num_checks++;
    if (s !== e) begin
      n_fail++;
      $display("unexpected %s expected %h seen %h", nm, e, s);
    end
  endtask : chk
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int n;
    @(posedge mclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge mclk);
    penable <= 1'b1;
    for (n = 0; n < 20; n++) begin
      @(posedge mclk);
      if (pready === 1'b1) break;
    end
    if (n == 20) tmo();
    q = prdata;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  // A device access is polled through the busy bit, so no latency is assumed.
  task automatic dev(input logic w, input logic [4:0] a, input logic [31:0] d);
    int n;
    if (w) apb(1'b1, OFF_DATA, d);
    apb(1'b1, OFF_CMD, {w, 26'h0, a});
    for (n = 0; n < 20; n++) begin
      apb(1'b0, OFF_CMD, 32'h0);
      if (q[CMD_BUSY_BIT] === 1'b0) break;
    end
    if (n == 20) tmo();
    apb(1'b0, OFF_DATA, 32'h0);
  endtask : dev
  task automatic wait_taken(input logic [3:0] s, input logic clr);
    int n;
    for (n = 0; n < 100; n++) begin
      apb(1'b0, OFF_TAKEN, 32'h0);
      if (q[TAKEN_VALID_BIT] === 1'b1) break;
    end
    if (n == 100) tmo();
    chk("taken", q, {4'h8, s, 4'h8, s, 4'h1, s, BASE_UNIT_ID});
    if (clr) apb(1'b1, OFF_TAKEN, 32'h0);
  endtask : wait_taken
  task automatic idle_taken;
    apb(1'b0, OFF_TAKEN, 32'h0);
    chk("valid", {31'h0, q[TAKEN_VALID_BIT]}, 32'h0);
  endtask : idle_taken
  // ****************
  // Main sequence.
  // ****************
  initial begin
    rst_b = 1'b0;
    src_irq = '0;
    cmpl_src = '0;
    wr_pend = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = '0;
    pwdata = '0;
    q = '0;
    n_fail = 0;
    num_checks = 0;
    repeat (5) @(posedge mclk);
    rst_b <= 1'b1;
    apb(1'b0, OFF_PRIO, 32'h0);
    chk("prio", q, {24'h0, PRIO_RESET});
    apb(1'b0, 12'h010, 32'h0);
    chk("unmapped", q, 32'h0);
    chk("slverr", {31'h0, pslverr}, 32'h0);
    idle_taken();
    $display("test reset done");
    for (int i = 0; i < NUM_SRC; i++) begin
      dev(1'b1, {1'b0, 4'(i)}, {4'h1, 4'(i), 4'h8, 4'(i), 16'hbeef});
      dev(1'b0, {1'b0, 4'(i)}, 32'h0);
      chk("entry", q, {4'h1, 4'(i), 4'h8, 4'(i), 16'h0});
    end
    $display("test entries done");
    src_irq <= 16'h0024;
    wait_taken(4'd2, 1'b1);
    wait_taken(4'd5, 1'b1);
    chk("mask", {16'h0, masked}, 32'h0024);
    dev(1'b1, 5'h12, 32'h1234);
    wait_taken(4'd2, 1'b1);
    repeat (40) @(posedge mclk);
    idle_taken();
    dev(1'b0, 5'h15, 32'h0);
    chk("eos load", q, 32'h0);
    wait_taken(4'd5, 1'b1);
    src_irq <= '0;
    $display("test order and end of service done");
    apb(1'b1, OFF_PRIO, 32'h0);
    src_irq <= 16'h0080;
    repeat (60) @(posedge mclk);
    idle_taken();
    apb(1'b1, OFF_PRIO, 32'hff);
    wait_taken(4'd7, 1'b0);
    apb(1'b1, OFF_PRIO, 32'h17);
    idle_taken();
    apb(1'b1, OFF_PRIO, 32'hff);
    wait_taken(4'd7, 1'b1);
    src_irq <= '0;
    $display("test rejection done");
    cmpl_src <= 16'h0200;
    wr_pend <= 1'b1;
    src_irq <= 16'h0200;
    repeat (40) @(posedge mclk);
    chk("flush", {31'h0, flush_req}, 32'h1);
    idle_taken();
    wr_pend <= 1'b0;
    wait_taken(4'd9, 1'b1);
    chk("flush", {31'h0, flush_req}, 32'h0);
    $display("test completion done");
    finish_test();
  end
endmodule : io_unit_interrupt_presenter_tb
